// *** pkg/ssi_defs.svh ***
// Constants of the scanner status indicator: offsets, fields, resets, timing.
// Assumes a 100 MHz core clock; included by every design file that needs it.
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSI_ADDR_W 4
`define SSI_REG_CTRL 4'h0
`define SSI_REG_STATUS 4'h1
`define SSI_REG_IRQ_STAT 4'h2
`define SSI_REG_IRQ_MASK 4'h3
`define SSI_REG_PASSWORD 4'h4
`define SSI_REG_CONFIG 4'h5
`define SSI_REG_LAMPS 4'h6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SSI_CTRL_LINKUP 0
`define SSI_CTRL_SETTINGS_DONE 1
`define SSI_CTRL_ZONES_DONE 2
`define SSI_CTRL_LOGOUT 3

// Configuration fields: interlock enable, alarm sources, zone size
`define SSI_CFG_INTERLOCK 0
`define SSI_CFG_ALM_WARNFLD 1
`define SSI_CFG_ALM_WARNMSG 2
`define SSI_CFG_ALM_ERRMSG 3
`define SSI_CFG_ALM_INTERR 4
`define SSI_CFG_ZONE_LSB 8
`define SSI_CFG_ZONE_MSB 11
`define SSI_CFG_RESET 32'h0000_0F1F

// Interrupt status bits
`define SSI_IRQ_ZONE 0
`define SSI_IRQ_ERROR 1
`define SSI_IRQ_DIRT 2
`define SSI_IRQ_RESTART 3
`define SSI_IRQ_W 4

// Password value compared against writes; arbitrary
`define SSI_PASSWORD_DEFAULT 32'h5A5A_1234

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSI_CLK_HZ 100000000
`define SSI_SLOW_HZ_X100 25
`define SSI_FAST_HZ 4
// Half periods in cycles for 0.25 Hz and 4 Hz
`define SSI_SLOW_HALF ((`SSI_CLK_HZ / `SSI_SLOW_HZ_X100) * 50)
`define SSI_FAST_HALF (`SSI_CLK_HZ / (2 * `SSI_FAST_HZ))

`endif

// *** pkg/ssi_pkg.sv ***
// Types of the scanner status indicator.
// Assumes nothing of its surroundings.
package ssi_pkg;

    // Boot and configuration sequence, Gray coded along the usual path
    typedef enum logic [2:0] {
        SSI_BOOT = 3'b000,
        SSI_CONNECT = 3'b001,
        SSI_LOCKED = 3'b011,
        SSI_UNLOCKED = 3'b010,
        SSI_READY = 3'b110
    } ssi_state_t;

    // Measured scene reported by the field evaluation
    typedef struct packed {
        logic zoneHit;
        logic warnHit;
        logic warnMsg;
        logic errMsg;
        logic intErr;
        logic dirt;
    } ssi_scene_t;

    // Front-panel lamps
    typedef struct packed {
        logic lampOne;
        logic lampTwo;
        logic lampThree;
        logic lampFour;
        logic lampFive;
    } ssi_lamps_t;

endpackage : ssi_pkg

// *** hw/ssi_blinker.sv ***
// Square-wave divider for one lamp flash rate.
// Assumes a free-running clock; output comes from a flip-flop.
`timescale 1ns/1ns
module ssi_blinker
#(
    parameter int HALF = 4
)
(
    input wire logic refClk,
    input wire logic nrst,
    output logic wave
);
    localparam int CW = $clog2(HALF + 1);

    logic [CW-1:0] count; // Cycles in current half period
    logic [CW-1:0] next_count;
    logic next_wave;

    // ----------------------------------------
    // Next-value logic
    // ----------------------------------------
    always_comb
    begin
        next_count = count + 1'b1;
        next_wave = wave;
        if (count == CW'(HALF - 1))
        begin
            next_count = '0;
            next_wave = ~wave;
        end
    end

    // Registers
    always_ff @(posedge refClk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
            wave <= 1'b0;
        end
        else
        begin
            count <= next_count;
            wave <= next_wave;
        end
    end
endmodule : ssi_blinker

// *** hw/ssi_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/1ns
module ssi_sync
#(
    parameter int W = 1
)
(
    input wire logic refClk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta; // First stage, read only by the second

    // Two registered stages
    always_ff @(posedge refClk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : ssi_sync

// *** hw/scanner_status_indicator.sv ***
// Front-panel status lamps, safety outputs and start-up sequence of the scanner.
// Assumes field evaluation and serial link logic on ref_clk; pins are asynchronous.
//
// Function
// - Lamp one: sensing and zone clear
// - Lamp two: object in warning field
// - Lamp three: both safety outputs off
// - Lamp four: both safety outputs on
// - Outputs held off while booting
// - Warning field alone keeps outputs on
// - Lamp five: steady, slow, fast; error forces fast
// - Default: largest zone, interlock active
// - Attempt host contact after power-up
// - Changes only after link and password
// - Ready after settings and zones transferred
// - Report window dirt as status
// - Four switch inputs pick field pair
// - Each channel off on zone violation
// - Alarm off on configured conditions
// - Restart input releases interlock
`timescale 1ns/1ns
`include "ssi_defs.svh"
module scanner_status_indicator
(
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [`SSI_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic irq,
    // Scene from field evaluation, same clock
    input wire ssi_pkg::ssi_scene_t scene,
    // Pins
    input wire logic [3:0] fieldPairSelectPin,
    input wire logic restartPin,
    output logic [1:0] safetySwitchOutput,
    output logic alarmOutput,
    output logic hostConnectReq,
    output logic [1:0] activeFieldPair,
    output ssi_pkg::ssi_lamps_t lamps
);
    // ----------------------------------------
    // Pin synchronisers and blink dividers
    // ----------------------------------------
    logic [4:0] pinSync; // Synchronised pins
    logic slowWave; // 0.25 Hz square wave
    logic fastWave; // 4 Hz square wave

    ssi_sync #(.W(5)) uSync
    (
        .refClk(ref_clk),
        .nrst(nrst),
        .din({restartPin, fieldPairSelectPin}),
        .dout(pinSync)
    );

    ssi_blinker #(.HALF(`SSI_SLOW_HALF)) uSlow
    (
        .refClk(ref_clk),
        .nrst(nrst),
        .wave(slowWave)
    );

    ssi_blinker #(.HALF(`SSI_FAST_HALF)) uFast
    (
        .refClk(ref_clk),
        .nrst(nrst),
        .wave(fastWave)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    ssi_pkg::ssi_state_t state, next_state; // Start-up sequence
    logic settingsDone, next_settingsDone; // Scanner settings transferred
    logic zonesDone, next_zonesDone; // Zone configurations transferred
    logic [31:0] config_, next_config; // Configuration register
    logic [31:0] password, next_password; // Stored password
    logic interlock, next_interlock; // Restart interlock latched
    logic restartPrev, next_restartPrev; // Restart edge detector
    logic [1:0] pairSel, next_pairSel; // Active field pair
    logic [`SSI_IRQ_W-1:0] irqStat, next_irqStat; // Sticky events
    logic [`SSI_IRQ_W-1:0] irqMask, next_irqMask; // Event mask
    logic [31:0] next_regRdata;
    logic [1:0] next_safety;
    logic next_alarm;
    ssi_pkg::ssi_lamps_t next_lamps;
    logic [`SSI_IRQ_W-1:0] events; // Events this cycle
    logic restartRise; // Restart button pressed
    logic measuring; // Sensing function running
    logic unlocked; // Parameter changes allowed
    logic writeCtrl, writeCfg, writePwd; // Decoded writes

    always_comb
    begin
        measuring = (state == ssi_pkg::SSI_READY);
        unlocked = (state == ssi_pkg::SSI_UNLOCKED);
        restartRise = pinSync[4] & ~restartPrev;
        writeCtrl = regWrite && (regAddr == `SSI_REG_CTRL);
        writeCfg = regWrite && (regAddr == `SSI_REG_CONFIG);
        writePwd = regWrite && (regAddr == `SSI_REG_PASSWORD);
        events = '0;
        events[`SSI_IRQ_ZONE] = measuring & scene.zoneHit;
        events[`SSI_IRQ_ERROR] = scene.errMsg | scene.intErr;
        events[`SSI_IRQ_DIRT] = scene.dirt;
        events[`SSI_IRQ_RESTART] = restartRise;
    end

    // ----------------------------------------
    // Start-up sequence and configuration
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_settingsDone = settingsDone;
        next_zonesDone = zonesDone;
        next_config = config_;
        next_password = password;
        case (state)
            ssi_pkg::SSI_BOOT:
            begin
                next_state = ssi_pkg::SSI_CONNECT;
            end
            ssi_pkg::SSI_CONNECT:
            begin
                // Host link reported up
                if (writeCtrl && regWdata[`SSI_CTRL_LINKUP])
                begin
                    next_state = ssi_pkg::SSI_LOCKED;
                end
            end
            ssi_pkg::SSI_LOCKED:
            begin
                // Correct password opens the parameter level
                if (writePwd && regWdata == password)
                begin
                    next_state = ssi_pkg::SSI_UNLOCKED;
                end
            end
            ssi_pkg::SSI_UNLOCKED:
            begin
                if (writeCfg)
                begin
                    next_config = regWdata;
                end
                if (writeCtrl && regWdata[`SSI_CTRL_SETTINGS_DONE])
                begin
                    next_settingsDone = 1'b1;
                end
                if (writeCtrl && regWdata[`SSI_CTRL_ZONES_DONE])
                begin
                    next_zonesDone = 1'b1;
                end
                if (next_settingsDone && next_zonesDone)
                begin
                    next_state = ssi_pkg::SSI_READY;
                end
            end
            ssi_pkg::SSI_READY:
            begin
                // Reconfiguration needs a fresh unlock
                if (writePwd && regWdata == password)
                begin
                    next_state = ssi_pkg::SSI_UNLOCKED;
                    next_settingsDone = 1'b0;
                    next_zonesDone = 1'b0;
                end
            end
            default:
            begin
                next_state = ssi_pkg::SSI_BOOT;
            end
        endcase
        // Logout relocks from the unlocked level
        if (unlocked && writeCtrl && regWdata[`SSI_CTRL_LOGOUT])
        begin
            next_state = ssi_pkg::SSI_LOCKED;
        end
    end

    // ----------------------------------------
    // Interlock, field pair, interrupts
    // ----------------------------------------
    always_comb
    begin
        next_restartPrev = pinSync[4];
        next_interlock = interlock;
        // Interlock arms whenever outputs drop, if enabled
        if (config_[`SSI_CFG_INTERLOCK] && (!measuring || scene.zoneHit || events[`SSI_IRQ_ERROR]))
        begin
            next_interlock = 1'b1;
        end
        else if (restartRise)
        begin
            next_interlock = 1'b0;
        end
        else if (!config_[`SSI_CFG_INTERLOCK])
        begin
            next_interlock = 1'b0;
        end
        // Lowest asserted switch input chooses the pair
        next_pairSel = pairSel;
        if (pinSync[0])
        begin
            next_pairSel = 2'h0;
        end
        else if (pinSync[1])
        begin
            next_pairSel = 2'h1;
        end
        else if (pinSync[2])
        begin
            next_pairSel = 2'h2;
        end
        else if (pinSync[3])
        begin
            next_pairSel = 2'h3;
        end
        // Set wins over write-one-to-clear
        next_irqStat = irqStat;
        if (regWrite && regAddr == `SSI_REG_IRQ_STAT)
        begin
            next_irqStat = irqStat & ~regWdata[`SSI_IRQ_W-1:0];
        end
        next_irqStat = next_irqStat | events;
        next_irqMask = irqMask;
        if (regWrite && regAddr == `SSI_REG_IRQ_MASK)
        begin
            next_irqMask = regWdata[`SSI_IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // Outputs and lamps
    // ----------------------------------------
    always_comb
    begin
        // Both channels on only while measuring clear; warning field ignored
        next_safety = 2'b11;
        if (!measuring || scene.zoneHit || interlock || scene.errMsg || scene.intErr)
        begin
            next_safety = 2'b00;
        end
        // Alarm is active high healthy, switches off on selected causes
        next_alarm = measuring;
        if ((config_[`SSI_CFG_ALM_WARNFLD] && scene.warnHit) ||
            (config_[`SSI_CFG_ALM_WARNMSG] && (scene.warnMsg || scene.dirt)) ||
            (config_[`SSI_CFG_ALM_ERRMSG] && scene.errMsg) ||
            (config_[`SSI_CFG_ALM_INTERR] && scene.intErr))
        begin
            next_alarm = 1'b0;
        end
        next_lamps.lampOne = measuring & ~scene.zoneHit;
        next_lamps.lampTwo = measuring & scene.warnHit;
        next_lamps.lampThree = (safetySwitchOutput == 2'b00);
        next_lamps.lampFour = (safetySwitchOutput == 2'b11);
        // Error beats warning beats interlock
        if (scene.errMsg || scene.intErr)
        begin
            next_lamps.lampFive = fastWave;
        end
        else if (scene.warnMsg || scene.dirt)
        begin
            next_lamps.lampFive = slowWave;
        end
        else
        begin
            next_lamps.lampFive = interlock;
        end
    end

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always_comb
    begin
        next_regRdata = 32'h0000_0000;
        if (regRead)
        begin
            if (regAddr == `SSI_REG_CTRL)
            begin
                next_regRdata = {29'h0, zonesDone, settingsDone, (state != ssi_pkg::SSI_CONNECT)};
            end
            else if (regAddr == `SSI_REG_STATUS)
            begin
                next_regRdata = {22'h0, state, pairSel, interlock, scene.dirt, safetySwitchOutput, measuring};
            end
            else if (regAddr == `SSI_REG_IRQ_STAT)
            begin
                next_regRdata = {28'h0, irqStat};
            end
            else if (regAddr == `SSI_REG_IRQ_MASK)
            begin
                next_regRdata = {28'h0, irqMask};
            end
            else if (regAddr == `SSI_REG_CONFIG)
            begin
                next_regRdata = config_;
            end
            else if (regAddr == `SSI_REG_LAMPS)
            begin
                next_regRdata = {27'h0, lamps};
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ssi_pkg::SSI_BOOT;
            settingsDone <= 1'b0;
            zonesDone <= 1'b0;
            config_ <= `SSI_CFG_RESET;
            password <= `SSI_PASSWORD_DEFAULT;
            interlock <= 1'b1;
            restartPrev <= 1'b0;
            pairSel <= 2'h0;
            irqStat <= '0;
            irqMask <= '0;
            regRdata <= 32'h0000_0000;
            safetySwitchOutput <= 2'b00;
            alarmOutput <= 1'b0;
            lamps <= 5'b00101;
        end
        else
        begin
            state <= next_state;
            settingsDone <= next_settingsDone;
            zonesDone <= next_zonesDone;
            config_ <= next_config;
            password <= next_password;
            interlock <= next_interlock;
            restartPrev <= next_restartPrev;
            pairSel <= next_pairSel;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
            regRdata <= next_regRdata;
            safetySwitchOutput <= next_safety;
            alarmOutput <= next_alarm;
            lamps <= next_lamps;
        end
    end

    assign irq = |(irqStat & irqMask);
    assign hostConnectReq = (state == ssi_pkg::SSI_CONNECT);
    assign activeFieldPair = pairSel;
endmodule : scanner_status_indicator

// *** tb/ssi_status_props.sv ***
// Port checker of the scanner status indicator, bound to its top module.
// Assumes the single ref_clk domain and nrst active low.
`timescale 1ns/1ns
`include "ssi_defs.svh"
module ssi_status_props
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [`SSI_ADDR_W-1:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire ssi_pkg::ssi_scene_t scene,
    input wire logic [3:0] fieldPairSelectPin,
    input wire logic [1:0] safetySwitchOutput,
    input wire logic hostConnectReq,
    input wire logic [1:0] activeFieldPair,
    input wire ssi_pkg::ssi_lamps_t lamps
);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // Pins quiet long enough to flush the synchroniser
    sequence pinsIdle;
        (fieldPairSelectPin == 4'h0) [*4];
    endsequence
    // Zone violation or error on the scene
    sequence tripSeen;
        scene.zoneHit || scene.errMsg || scene.intErr;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    boot_off_a: assert property (hostConnectReq |-> safetySwitchOutput == 2'h0)
        else $error("safety outputs on while waiting for host");
    lamp_three_a: assert property (1'b1 |=> lamps.lampThree == ($past(safetySwitchOutput) == 2'h0))
        else $error("lamp three does not follow outputs off");
    lamp_four_a: assert property (1'b1 |=> lamps.lampFour == ($past(safetySwitchOutput) == 2'h3))
        else $error("lamp four does not follow outputs on");
    trip_off_a: assert property (tripSeen |=> safetySwitchOutput == 2'h0)
        else $error("safety outputs on after violation or error");
    warn_lamp_a: assert property (1'b1 |=> lamps.lampTwo == $past(scene.warnHit))
        else $error("lamp two does not follow warning field");
    pair_hold_a: assert property (pinsIdle |=> $stable(activeFieldPair))
        else $error("field pair changed with no pin active");
    twin_ch_a: assert property (safetySwitchOutput[0] == safetySwitchOutput[1])
        else $error("safety channels disagree");
    hidden_pw_a: assert property (regRead && regAddr == `SSI_REG_PASSWORD |=> regRdata == 32'h0)
        else $error("password readable");
    idle_rdata_a: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data outside read answer");
endmodule : ssi_status_props

bind scanner_status_indicator ssi_status_props ssi_status_props_i
(
    .ref_clk(ref_clk),
    .nrst(nrst),
    .regAddr(regAddr),
    .regRead(regRead),
    .regRdata(regRdata),
    .scene(scene),
    .fieldPairSelectPin(fieldPairSelectPin),
    .safetySwitchOutput(safetySwitchOutput),
    .hostConnectReq(hostConnectReq),
    .activeFieldPair(activeFieldPair),
    .lamps(lamps)
);

// *** tb/ssi_panel_model.sv ***
// Switch panel wired to the field pair and restart pins.
// Assumes requests from the bench; contacts settle off the clock edges.
`timescale 1ns/1ns
module ssi_panel_model
(
    input wire logic [3:0] pairReq,
    input wire logic pressReq,
    output logic [3:0] fieldPairSelectPin,
    output logic restartPin
);
    // Contacts move 3 ns after the request, unrelated to ref_clk
    assign #3 fieldPairSelectPin = pairReq;
    assign #3 restartPin = pressReq;
endmodule : ssi_panel_model

// *** tb/scanner_status_indicator_bench.sv ***
// Self-checking bench of the scanner status indicator.
// Assumes the design, its package and header, and the switch panel model.
`timescale 1ns/1ns
`include "ssi_defs.svh"
module scanner_status_indicator_bench;
    logic ref_clk;
    logic nrst;
    logic [`SSI_ADDR_W-1:0] regAddr;
    logic [31:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [31:0] regRdata;
    logic irq;
    ssi_pkg::ssi_scene_t scene;
    logic [3:0] pairReq;
    logic pressReq;
    logic [3:0] fieldPairSelectPin;
    logic restartPin;
    logic [1:0] safetySwitchOutput;
    logic alarmOutput;
    logic hostConnectReq;
    logic [1:0] activeFieldPair;
    ssi_pkg::ssi_lamps_t lamps;
    int badCount;
    int samplesChecked;
    logic [31:0] rnd;
    logic [31:0] got;
    logic [3:0] pinVal;
    logic [1:0] expPair;
    logic [3:0] pinQ[$];

    scanner_status_indicator scanner_status_indicator_i
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(regRdata),
        .irq(irq),
        .scene(scene),
        .fieldPairSelectPin(fieldPairSelectPin),
        .restartPin(restartPin),
        .safetySwitchOutput(safetySwitchOutput),
        .alarmOutput(alarmOutput),
        .hostConnectReq(hostConnectReq),
        .activeFieldPair(activeFieldPair),
        .lamps(lamps)
    );
    ssi_panel_model ssi_panel_model_i
    (
        .pairReq(pairReq),
        .pressReq(pressReq),
        .fieldPairSelectPin(fieldPairSelectPin),
        .restartPin(restartPin)
    );
    // ----------------------------------------
    // Clock, tasks and verdict
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Next pseudo-random word
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Wait edges, then let their updates land
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd
    task sc(input ssi_pkg::ssi_scene_t v);
        @(posedge ref_clk);
        scene <= v;
        settle(3);
    endtask : sc
    // Restart button pressed and released
    task press();
        @(posedge ref_clk);
        pressReq <= 1'b1;
        settle(4);
        @(posedge ref_clk);
        pressReq <= 1'b0;
        settle(4);
    endtask : press
    task completeRun();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : completeRun
    // Watchdog far beyond the expected run of under two hundred cycles
    initial
    begin
        #200000;
        badCount++;
        completeRun();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        nrst = 1'b0;
        regAddr = '0;
        regWdata = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        scene = '0;
        pairReq = 4'h0;
        pressReq = 1'b0;
        badCount = 0;
        samplesChecked = 0;
        rnd = 32'hE1CAFE99;
        expPair = 2'h0;
        settle(12);
        check(32'(safetySwitchOutput), 32'h0);
        check(32'(lamps), 32'h05);
        @(posedge ref_clk);
        nrst <= 1'b1;
        settle(2);
        check(32'(hostConnectReq), 32'h1);
        // Locked: configuration writes ignored
        wr(`SSI_REG_CONFIG, 32'h0A1F);
        rd(`SSI_REG_CONFIG, got);
        check(got, `SSI_CFG_RESET);
        wr(`SSI_REG_CTRL, 32'h1);
        settle(2);
        check(32'(hostConnectReq), 32'h0);
        wr(`SSI_REG_PASSWORD, 32'h5A5A_1235);
        wr(`SSI_REG_CONFIG, 32'h0A1F);
        rd(`SSI_REG_CONFIG, got);
        check(got, `SSI_CFG_RESET);
        wr(`SSI_REG_PASSWORD, `SSI_PASSWORD_DEFAULT);
        wr(`SSI_REG_CONFIG, 32'h0A1F);
        rd(`SSI_REG_CONFIG, got);
        check(got, 32'h0A1F);
        // Logout relocks until the password is given again
        wr(`SSI_REG_CTRL, 32'h8);
        wr(`SSI_REG_CONFIG, 32'h0B1F);
        rd(`SSI_REG_CONFIG, got);
        check(got, 32'h0A1F);
        rd(`SSI_REG_STATUS, got);
        check(32'(got[9:7]), 32'h3);
        // Stored password never reads back
        rd(`SSI_REG_PASSWORD, got);
        check(got, 32'h0);
        wr(`SSI_REG_PASSWORD, `SSI_PASSWORD_DEFAULT);
        rd(`SSI_REG_STATUS, got);
        check(32'(got[9:7]), 32'h2);
        rd(4'hF, got);
        check(got, 32'h0);
        // Ready needs both transfers
        wr(`SSI_REG_CTRL, 32'h2);
        rd(`SSI_REG_STATUS, got);
        check(32'(got[9:7]), 32'h2);
        wr(`SSI_REG_CTRL, 32'h4);
        rd(`SSI_REG_STATUS, got);
        check(32'(got[9:7]), 32'h6);
        settle(3);
        check(32'(safetySwitchOutput), 32'h0);
        check(32'(lamps), 32'h15);
        press();
        check(32'(safetySwitchOutput), 32'h3);
        check(32'(lamps), 32'h12);
        check(32'(alarmOutput), 32'h1);
        sc(6'h10);
        check(32'(lamps), 32'h1A);
        check(32'(safetySwitchOutput), 32'h3);
        check(32'(alarmOutput), 32'h0);
        // Zone violation with its interrupt
        wr(`SSI_REG_IRQ_STAT, 32'hF);
        wr(`SSI_REG_IRQ_MASK, 32'h1);
        sc(6'h20);
        check(32'(safetySwitchOutput), 32'h0);
        check(32'(lamps), 32'h05);
        check(32'(irq), 32'h1);
        rd(`SSI_REG_IRQ_STAT, got);
        check(got, 32'h1);
        wr(`SSI_REG_IRQ_MASK, 32'h0);
        settle(1);
        check(32'(irq), 32'h0);
        sc(6'h00);
        wr(`SSI_REG_IRQ_STAT, 32'h1);
        rd(`SSI_REG_IRQ_STAT, got);
        check(got, 32'h0);
        // Error forces outputs off
        press();
        check(32'(safetySwitchOutput), 32'h3);
        sc(6'h04);
        check(32'(safetySwitchOutput), 32'h0);
        sc(6'h00);
        wr(`SSI_REG_IRQ_STAT, 32'hF);
        sc(6'h01);
        rd(`SSI_REG_IRQ_STAT, got);
        check(got, 32'h4);
        wr(`SSI_REG_IRQ_MASK, 32'h4);
        settle(1);
        check(32'(irq), 32'h1);
        // Random pin patterns, one forced idle
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            pinVal = (i == 3) ? 4'h0 : rnd[3:0];
            pinQ.push_back(pinVal);
            @(posedge ref_clk);
            pairReq <= pinVal;
            settle(5);
            pinVal = pinQ.pop_front();
            for (int k = 3; k >= 0; k--)
                if (pinVal[k])
                    expPair = k[1:0];
            check(32'(activeFieldPair), 32'(expPair));
        end
        completeRun();
    end
endmodule : scanner_status_indicator_bench
